// ===== shared/lgp_pkg.sv
// Shared constants and types for the LED grayscale PWM dimmer
package lgp_pkg;

    // Number of LED output channels
    localparam int LGP_CHANNELS = 16;

    // Width of a channel index
    localparam int LGP_CHAN_BITS = 4;

    // Brightness value width per channel
    localparam int LGP_GRAY_BITS = 12;

    // Counter is one bit wider so it can reach the end-of-frame count
    localparam int LGP_COUNT_BITS = 13;

    // Counter value at which every channel is past its value and the frame ends
    localparam logic [12:0] LGP_COUNT_END = 13'h1000;

    // Counter value at frame start
    localparam logic [12:0] LGP_COUNT_ZERO = 13'h0000;

    // Counter step per PWM clock edge
    localparam logic [12:0] LGP_COUNT_STEP = 13'h0001;

    // Brightness reset value
    localparam logic [11:0] LGP_GRAY_RESET = 12'h000;

    // System clock cycles of stagger between neighbouring channels
    localparam int LGP_STAGGER_STEP = 1;

    // Frame sequencer states
    typedef enum logic [0:0] {
        LGP_IDLE,
        LGP_RUN
    } lgp_state_t;

endpackage : lgp_pkg

// ===== logic/lgp_stagger.sv
// Per-channel delay line that staggers both edges of an LED drive level
`timescale 1ns/1ps
`default_nettype none

module lgp_stagger
    import lgp_pkg::*;
#(
    parameter int DEPTH = 0
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic levelIn,
    output var logic levelOut
);

    logic levelOut_next;

    generate
        if (DEPTH == 0) begin : g_direct
            // No delay: the output flop follows the target directly
            always_comb begin
                levelOut_next = clear ? 1'b0 : levelIn;
            end
        end else begin : g_delay
            logic [DEPTH-1:0] pipe_reg;
            logic [DEPTH-1:0] pipe_next;
            logic [DEPTH:0] shifted;

            // Shift the target through DEPTH stages; clear empties the line
            always_comb begin
                shifted = {pipe_reg, levelIn};
                if (clear) begin
                    pipe_next = '0;
                    levelOut_next = 1'b0;
                end else begin
                    pipe_next = shifted[DEPTH-1:0];  // Oldest stage drops out
                    levelOut_next = pipe_reg[DEPTH-1];
                end
            end

            // Register the delay stages
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    pipe_reg <= '0;
                end else begin
                    pipe_reg <= pipe_next;
                end
            end
        end
    endgenerate

    // Output flop, same delay for turn-on and turn-off
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            levelOut <= 1'b0;
        end else begin
            levelOut <= levelOut_next;
        end
    end

endmodule : lgp_stagger

`default_nettype wire

// ===== logic/lgp_dimmer.sv
// LED grayscale PWM dimmer: shared counter, per-channel compare, staggered drive
//
// How it works
// - Each of the channels holds a 12-bit brightness, 4096 on-time levels.
// - Frame start forces every output off before any PWM edge is used.
// - First PWM rising edge turns on nonzero channels; zero channels stay off.
// - One shared counter steps by one on each PWM clock rising edge of a running frame.
// - A channel stays on until the counter exceeds its value: N PWM cycles.
// - Turn-on moments are staggered channel by channel, never all at once.
// - Turn-off moments are staggered the same way as turn-on, except that frame start turns every output off at once.
`timescale 1ns/1ps
`default_nettype none

module lgp_dimmer
    import lgp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic frameStart,
    input wire logic pwmClk,
    input wire logic grayWrEn,
    input wire logic [3:0] grayWrChan,
    input wire logic [11:0] grayWrData,
    output var logic [15:0] ledOn,
    output var logic frameActive,
    output var logic frameDone
);

    // Sequencer state
    lgp_state_t state_reg;
    lgp_state_t state_next;

    // Shared grayscale counter and PWM edge detection
    logic [LGP_COUNT_BITS-1:0] gsCount_reg;
    logic [LGP_COUNT_BITS-1:0] gsCount_next;
    logic pwmPrev_reg;
    logic pwmPrev_next;
    logic pwmRise;

    // Frame flags driven out, and the end-of-count event behind the done pulse
    logic frameActive_next;
    logic frameDone_next;
    logic frameEnd;

    // Counter value one PWM step ahead
    logic [LGP_COUNT_BITS-1:0] countStep;

    // Brightness staging: written values, and the copy used by the running frame
    logic [LGP_GRAY_BITS-1:0] grayWr_reg [LGP_CHANNELS];
    logic [LGP_GRAY_BITS-1:0] grayWr_next [LGP_CHANNELS];
    logic [LGP_GRAY_BITS-1:0] grayLive_reg [LGP_CHANNELS];
    logic [LGP_GRAY_BITS-1:0] grayLive_next [LGP_CHANNELS];

    // Undelayed per-channel drive level
    logic [LGP_CHANNELS-1:0] target;

    // High while a running frame has seen its first PWM edge
    logic litWindow;

    // Rising edge of the PWM clock, sampled as a plain synchronous input
    always_comb begin
        pwmRise = pwmClk & ~pwmPrev_reg;
        pwmPrev_next = pwmClk;
    end

    // Register the PWM sample used by the edge detector; idle level is low
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwmPrev_reg <= 1'b0;
        end else begin
            pwmPrev_reg <= pwmPrev_next;
        end
    end

    // Brightness writes land in the staging store at any time
    always_comb begin
        for (int i = 0; i < LGP_CHANNELS; i++) begin
            grayWr_next[i] = grayWr_reg[i];
        end
        if (grayWrEn) begin
            grayWr_next[grayWrChan] = grayWrData;
        end
    end

    // Frame start copies the staged values so a frame never sees a half update
    always_comb begin
        for (int i = 0; i < LGP_CHANNELS; i++) begin
            grayLive_next[i] = frameStart ? grayWr_next[i] : grayLive_reg[i];
        end
    end

    // Register the staging store
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < LGP_CHANNELS; i++) begin
                grayWr_reg[i] <= LGP_GRAY_RESET;
            end
        end else begin
            for (int i = 0; i < LGP_CHANNELS; i++) begin
                grayWr_reg[i] <= grayWr_next[i];
            end
        end
    end

    // Register the live copy that the compare uses
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < LGP_CHANNELS; i++) begin
                grayLive_reg[i] <= LGP_GRAY_RESET;
            end
        end else begin
            for (int i = 0; i < LGP_CHANNELS; i++) begin
                grayLive_reg[i] <= grayLive_next[i];
            end
        end
    end

    // Counter one step ahead, and the event that closes the frame
    always_comb begin
        countStep = gsCount_reg + LGP_COUNT_STEP;
        frameEnd = (state_reg == LGP_RUN) && pwmRise && !frameStart
            && (countStep == LGP_COUNT_END);
    end

    // Frame sequencer; frame start wins over a PWM edge in the same cycle
    always_comb begin
        state_next = state_reg;
        if (frameStart) begin
            state_next = LGP_RUN;
        end else begin
            unique case (state_reg)
                LGP_IDLE: begin
                    state_next = LGP_IDLE;
                end
                LGP_RUN: begin
                    if (frameEnd) begin
                        state_next = LGP_IDLE;
                    end
                end
            endcase
        end
    end

    // Register the sequencer state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= LGP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Shared counter: cleared by frame start, stepped by each PWM edge of a frame
    always_comb begin
        gsCount_next = gsCount_reg;
        if (frameStart) begin
            gsCount_next = LGP_COUNT_ZERO;
        end else if ((state_reg == LGP_RUN) && pwmRise) begin
            gsCount_next = countStep;
        end
    end

    // Register the shared counter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gsCount_reg <= LGP_COUNT_ZERO;
        end else begin
            gsCount_reg <= gsCount_next;
        end
    end

    // Frame flags follow the next sequencer state and the end-of-count event
    always_comb begin
        frameActive_next = (state_next == LGP_RUN);
        frameDone_next = frameEnd;
    end

    // Register the frame flags
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            frameActive <= 1'b0;
            frameDone <= 1'b0;
        end else begin
            frameActive <= frameActive_next;
            frameDone <= frameDone_next;
        end
    end

    // Outputs may be lit only after the first PWM edge of a running frame
    always_comb begin
        litWindow = (state_reg == LGP_RUN)
            && (gsCount_reg != LGP_COUNT_ZERO);
    end

    // Compare: each channel is on while the counter is not above its value
    always_comb begin
        for (int i = 0; i < LGP_CHANNELS; i++) begin
            target[i] = litWindow
                && (gsCount_reg <= {1'b0, grayLive_reg[i]});
        end
    end

    // Delay each channel by a multiple of its index so turn-on edges never coincide
    generate
        for (genvar ch = 0; ch < LGP_CHANNELS; ch++) begin : g_chan
            lgp_stagger #(
                .DEPTH(ch * LGP_STAGGER_STEP)
            ) u_stagger (
                .sys_clk(sys_clk),
                .arst_n(arst_n),
                .clear(frameStart),
                .levelIn(target[ch]),
                .levelOut(ledOn[ch])
            );
        end
    endgenerate

endmodule : lgp_dimmer

`default_nettype wire

// ===== dv/lgp_led_model.sv
// Sixteen LEDs that total the cycles each one is lit
`timescale 1ns/1ps
`default_nettype none
module lgp_led_model (
    input wire logic sys_clk,
    input wire logic clear,
    input wire logic [15:0] ledOn,
    output var int litCycles [16]
);
    // Each lit LED adds one cycle of light
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 16; i++) begin
            litCycles[i] <= clear ? 0 : litCycles[i] + int'(ledOn[i]);
        end
    end
endmodule : lgp_led_model
`default_nettype wire

// ===== dv/lgp_dimmer_chk.sv
// Port checker for the LED grayscale PWM dimmer
`timescale 1ns/1ps
`default_nettype none
module lgp_dimmer_chk (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic frameStart,
    input wire logic pwmClk,
    input wire logic [15:0] ledOn,
    input wire logic frameActive,
    input wire logic frameDone
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    AST_FRAME_OFF: assert property (frameStart |=> ledOn == 16'h0000)
        else $error("outputs lit after frame start");
    AST_FRAME_RUN: assert property (frameStart |=> frameActive)
        else $error("frame not running");
    AST_DONE_PULSE: assert property (frameDone |=> !frameDone)
        else $error("done longer than one cycle");
    AST_DONE_IDLE: assert property (frameDone && !frameStart |=> !frameActive)
        else $error("frame runs after done");
    AST_ON_STAGGER: assert property ($countones(ledOn & ~$past(ledOn)) <= 1)
        else $error("several outputs on at once");
    AST_OFF_STAGGER: assert property (!$past(frameStart) |->
        $countones(~ledOn & $past(ledOn)) <= 1) else $error("several outputs off at once");
    AST_END_DARK: assert property ($fell(frameActive) |-> ##16 ledOn == 16'h0000)
        else $error("output lit after frame end");
    AST_CH0_STEP: assert property ($changed(ledOn[0]) && !$past(frameStart) |->
        $past(pwmClk, 2) && !$past(pwmClk, 3)) else $error("channel 0 moved off step");
    COV_DONE: cover property (frameDone);
    COV_TOP_ON: cover property ($rose(ledOn[15]));
    COV_RESTART: cover property (frameStart && frameActive);
endmodule : lgp_dimmer_chk
bind lgp_dimmer lgp_dimmer_chk lgp_dimmer_chk_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .frameStart(frameStart), .pwmClk(pwmClk), .ledOn(ledOn), .frameActive(frameActive),
    .frameDone(frameDone));
`default_nettype wire

// ===== dv/lgp_dimmer_tb.sv
// Self-checking bench for the LED grayscale PWM dimmer
`timescale 1ns/1ps
`default_nettype none
module lgp_dimmer_tb;
    import lgp_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic frameStart = 1'b0;
    logic pwmClk = 1'b0;
    logic grayWrEn = 1'b0;
    logic [3:0] grayWrChan = 4'h0;
    logic [11:0] grayWrData = 12'h000;
    logic [15:0] ledOn;
    logic frameActive;
    logic frameDone;
    int litCycles [16];
    int n_mismatch = 0;
    int checked = 0;
    lgp_dimmer lgp_dimmer_inst (.sys_clk(sys_clk), .arst_n(arst_n), .frameStart(frameStart),
        .pwmClk(pwmClk), .grayWrEn(grayWrEn), .grayWrChan(grayWrChan),
        .grayWrData(grayWrData), .ledOn(ledOn), .frameActive(frameActive),
        .frameDone(frameDone));
    lgp_led_model lgp_led_model_inst (.sys_clk(sys_clk), .clear(frameStart), .ledOn(ledOn),
        .litCycles(litCycles));
    // System clock, 40 ns period
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // One PWM period of 20 system clocks
    task automatic rise();
        pwmClk <= 1'b1;
        tick(10);
        pwmClk <= 1'b0;
        tick(10);
    endtask : rise
    task automatic wr(input logic [3:0] ch, input logic [11:0] val);
        grayWrEn <= 1'b1;
        grayWrChan <= ch;
        grayWrData <= val;
        tick(1);
    endtask : wr
    task automatic start();
        frameStart <= 1'b1;
        grayWrEn <= 1'b0;
        tick(1);
        frameStart <= 1'b0;
        #1 check("ledOn", 32'(ledOn), 32'h0);
        check("frameActive", 32'(frameActive), 32'h1);
        tick(1);
    endtask : start
    // Channel i holds i: staggered turn-on and on-time of i periods
    task automatic scn_stagger();
        for (int i = 0; i < 16; i++) wr(4'(i), 12'(i));
        start();
        pwmClk <= 1'b1;
        for (int j = 1; j < 18; j++) begin
            tick(1);
            #1 check("ledOn", 32'(ledOn), ((32'h1 << (j - 1)) - 1) & 32'hfffe);
        end
        tick(1);
        pwmClk <= 1'b0;
        tick(2);
        repeat (19) rise();
        for (int i = 0; i < 16; i++) check("litCycles", litCycles[i], i * 20);
    endtask : scn_stagger
    // Frame start in mid-frame darkens every lit output
    task automatic scn_restart();
        start();
        rise();
        #1 check("ledOn", 32'(ledOn), 32'hfffe);
        tick(1);
        start();
    endtask : scn_restart
    // Two channels at the largest value: full frame, staggered turn-off, then idle
    task automatic scn_full();
        bit done = 1'b0;
        wr(4'he, 12'hfff);
        wr(4'hf, 12'hfff);
        start();
        repeat (4095) rise();
        pwmClk <= 1'b1;
        for (int k = 0; k < 30 && !done; k++) begin
            tick(1);
            #1 done = (frameDone === 1'b1);
        end
        if (!done) begin
            n_mismatch++;
            results();
        end else begin
            check("frameActive", 32'(frameActive), 32'h0);
            tick(15);
            #1 check("ledOn", 32'(ledOn), 32'h8000);
            tick(5);
            #1 check("ledOn", 32'(ledOn), 32'h0);
            check("litCycles", litCycles[15], 4095 * 20);
            check("litCycles", litCycles[14], 4095 * 20);
            check("litCycles", litCycles[1], 20);
        end
    endtask : scn_full
    initial begin
        tick(4);
        arst_n <= 1'b1;
        tick(1);
        scn_stagger();
        scn_restart();
        scn_full();
        results();
    end
endmodule : lgp_dimmer_tb
`default_nettype wire
